// File: cooling_pkg.sv
package cooling_pkg;
	// Clock rate in Hz
	localparam int unsigned CLK_HZ = 100_000_000;
	// Minimum spacing between cooling evaluations, seconds
	localparam int unsigned EVAL_PERIOD_S = 30;
	// Cycles between evaluations
	localparam longint unsigned EVAL_CYCLES = longint'(EVAL_PERIOD_S) * CLK_HZ;
	// Flash half period: one second lit, one second dark
	localparam int unsigned FLASH_HALF_S = 1;
	localparam longint unsigned FLASH_CYCLES = longint'(FLASH_HALF_S) * CLK_HZ;
	// Temperature width and default values
	localparam int unsigned TEMP_W = 10;
	localparam logic [9:0] CRIT_TEMP_RST = 10'h050;
	localparam logic [9:0] MARGIN_RST = 10'h005;
	// Number of transceiver units per cabinet
	localparam int unsigned UNITS = 4;
	// Cooling states
	typedef enum logic [1:0] {
		COOL_OFF = 2'b01,
		COOL_ON  = 2'b10
	} cool_state_e;
endpackage

// File: cooling_and_fault_indicator_ctrl.sv
`timescale 1ns/10ps
module cooling_and_fault_indicator_ctrl #(
	parameter int unsigned UNITS = cooling_pkg::UNITS,
	parameter int unsigned TEMP_W = cooling_pkg::TEMP_W,
	parameter longint unsigned EVAL_CYCLES = cooling_pkg::EVAL_CYCLES,
	parameter longint unsigned FLASH_CYCLES = cooling_pkg::FLASH_CYCLES
) (
	input  wire logic                    clk_in,
	input  wire logic                    rst_in,
	input  wire logic [UNITS*TEMP_W-1:0] unit_temp_in,
	input  wire logic [UNITS-1:0]        power_limited_in,
	input  wire logic [TEMP_W-1:0]       critical_temperature_in,
	input  wire logic [TEMP_W-1:0]       temp_margin_in,
	input  wire logic                    start_in,
	input  wire logic                    energy_unit_reset_in,
	input  wire logic                    fan_fail_in,
	input  wire logic                    unit_fault_in,
	input  wire logic                    base_app_in,
	input  wire logic                    lost_superior_in,
	input  wire logic                    flash_disable_in,
	input  wire logic                    station_fault_in,
	output logic                         max_cooling_out,
	output logic                         fan_cmd_out,
	output logic                         fault_log_out,
	output logic                         unit_fault_led_out,
	output logic                         station_fault_led_out
);

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers, all pins pass two flops
	localparam int unsigned SW = UNITS*TEMP_W + UNITS + 2*TEMP_W + 8;
	logic [SW-1:0] sync1_reg;        // First stage, read only by second
	logic [SW-1:0] sync2_reg;        // Second stage, used by logic
	logic [SW-1:0] pins;             // Raw pin bundle

	assign pins = {unit_temp_in, power_limited_in, critical_temperature_in,
		temp_margin_in, start_in, energy_unit_reset_in, fan_fail_in,
		unit_fault_in, base_app_in, lost_superior_in, flash_disable_in,
		station_fault_in};

	// Two flop synchroniser
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
		end
	end

	logic [UNITS*TEMP_W-1:0] temps_s;    // Synced temperatures
	logic [UNITS-1:0]        limited_s;  // Synced power limit flags
	logic [TEMP_W-1:0]       crit_s;     // Synced critical threshold
	logic [TEMP_W-1:0]       margin_s;   // Synced hysteresis margin
	logic start_s, ecu_rst_s, fail_s, ufault_s, base_s, lost_s, fdis_s;
	logic sfault_s;                      // Synced station fault

	assign {temps_s, limited_s, crit_s, margin_s, start_s, ecu_rst_s,
		fail_s, ufault_s, base_s, lost_s, fdis_s, sfault_s} =
		sync2_reg;

	////////////////////////////////////////////////////////////////////////
	// Per unit comparison against threshold and hysteresis floor
	logic [UNITS-1:0] over_crit;         // Unit above critical temperature
	logic [UNITS-1:0] below_floor;       // Unit more than margin below
	logic [TEMP_W:0]  floor_w;           // Threshold minus margin, signed
	assign floor_w = {1'b0, crit_s} - {1'b0, margin_s};

	genvar gi;
	generate
		for (gi = 0; gi < UNITS; gi++) begin : g_unit
			assign over_crit[gi] = temps_s[gi*TEMP_W +: TEMP_W] > crit_s;
			assign below_floor[gi] = !floor_w[TEMP_W] &&
				(temps_s[gi*TEMP_W +: TEMP_W] < floor_w[TEMP_W-1:0]);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Cooling state, evaluation timer and fan command
	cooling_pkg::cool_state_e state_reg, state_next;
	logic [63:0] eval_cnt_reg, eval_cnt_next;    // Cycles since last state change or start
	logic        started_reg, started_next;      // Function initiated
	logic        ecu_d_reg, ecu_d_next;          // Delayed energy reset
	logic        start_d_reg, start_d_next;      // Delayed start
	logic        cmd_reg, cmd_next;              // Fan command pulse
	logic        cmd_pend_reg, cmd_pend_next;    // Command sent, await fail
	logic        log_reg, log_next;              // Fault log pulse
	logic        want_on, want_off, eval_now;

	// Next state of the cooling controller
	always_comb begin
		state_next = state_reg;
		eval_cnt_next = eval_cnt_reg;
		started_next = started_reg;
		ecu_d_next = ecu_rst_s;
		start_d_next = start_s;
		cmd_next = 1'b0;
		log_next = 1'b0;
		cmd_pend_next = cmd_pend_reg;
		want_on = (|over_crit) || (|limited_s);
		// OFF only when all cool and none limited
		want_off = (&below_floor) && !(|limited_s);
		// evaluation permitted after the full spacing
		eval_now = eval_cnt_reg >= EVAL_CYCLES - 64'h1;
		if (eval_cnt_reg < EVAL_CYCLES - 64'h1) begin
			eval_cnt_next = eval_cnt_reg + 64'h1;
		end
		if (start_s && !start_d_reg) begin
			started_next = 1'b1;
			cmd_next = 1'b1;
			eval_cnt_next = '0;
			// one cabinet state from all units
			state_next = want_on ? cooling_pkg::COOL_ON :
				cooling_pkg::COOL_OFF;
		end else if (started_reg) begin
			if (eval_now) begin
				unique case (state_reg)
					cooling_pkg::COOL_OFF: begin
						if (want_on) begin
							state_next = cooling_pkg::COOL_ON;
							cmd_next = 1'b1;
							eval_cnt_next = '0;
						end
					end
					cooling_pkg::COOL_ON: begin
						if (want_off) begin
							state_next = cooling_pkg::COOL_OFF;
							cmd_next = 1'b1;
							eval_cnt_next = '0;
						end
					end
					default: state_next = cooling_pkg::COOL_OFF;
				endcase
			end
			// resend after energy unit reset ends
			if (!ecu_rst_s && ecu_d_reg) begin
				cmd_next = 1'b1;
			end
		end
		// failure after a command only logs
		if (cmd_pend_reg && fail_s) begin
			log_next = 1'b1;
			cmd_pend_next = 1'b0;
		end
		// New command re-arms the wait; set wins over clear
		if (cmd_reg) begin
			cmd_pend_next = 1'b1;
		end
	end

	// Cooling registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= cooling_pkg::COOL_OFF;
			eval_cnt_reg <= '0;
			started_reg <= 1'b0;
			ecu_d_reg <= 1'b0;
			start_d_reg <= 1'b0;
			cmd_reg <= 1'b0;
			cmd_pend_reg <= 1'b0;
			log_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			eval_cnt_reg <= eval_cnt_next;
			started_reg <= started_next;
			ecu_d_reg <= ecu_d_next;
			start_d_reg <= start_d_next;
			cmd_reg <= cmd_next;
			cmd_pend_reg <= cmd_pend_next;
			log_reg <= log_next;
		end
	end

	assign max_cooling_out = (state_reg == cooling_pkg::COOL_ON);
	assign fan_cmd_out = cmd_reg;
	assign fault_log_out = log_reg;

	////////////////////////////////////////////////////////////////////////
	// Flash divider and indicators
	logic [63:0] flash_cnt_reg, flash_cnt_next;  // Half period counter
	logic        phase_reg, phase_next;          // Lit phase of flash
	logic        uled_reg, uled_next;            // Unit indicator
	logic        sled_reg, sled_next;            // Station indicator
	logic        flash_cond;

	// Next values of the indicators
	always_comb begin
		flash_cnt_next = flash_cnt_reg + 64'h1;
		phase_next = phase_reg;
		// divide clock into one second halves
		if (flash_cnt_reg >= FLASH_CYCLES - 64'h1) begin
			flash_cnt_next = '0;
			phase_next = !phase_reg;
		end
		flash_cond = (base_s || lost_s) && !fdis_s;
		if (ufault_s) begin
			uled_next = 1'b1;
		end else if (flash_cond) begin
			uled_next = phase_reg;
		end else begin
			uled_next = 1'b0;
		end
		sled_next = sfault_s;
	end

	// Indicator registers
	// reset ends handling
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			flash_cnt_reg <= '0;
			phase_reg <= 1'b1;
			uled_reg <= 1'b0;
			sled_reg <= 1'b0;
		end else begin
			flash_cnt_reg <= flash_cnt_next;
			phase_reg <= phase_next;
			uled_reg <= uled_next;
			sled_reg <= sled_next;
		end
	end

	assign unit_fault_led_out = uled_reg;
	assign station_fault_led_out = sled_reg;

endmodule

// File: cooling_assertions.sv
`timescale 1ns/10ps
// Port checker for the cooling and indicator controller
module cooling_checker #(
	parameter longint unsigned EVAL_CYCLES = 20
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic unit_fault_in,
	input wire logic base_app_in,
	input wire logic lost_superior_in,
	input wire logic flash_disable_in,
	input wire logic station_fault_in,
	input wire logic fan_fail_in,
	input wire logic max_cooling_out,
	input wire logic fan_cmd_out,
	input wire logic fault_log_out,
	input wire logic unit_fault_led_out,
	input wire logic station_fault_led_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic            dark;     // No cause to light the unit lamp
	logic            cool_reg; // State seen last cycle
	longint unsigned age_reg;  // Cycles since last state change
	longint unsigned age_next;
	assign dark = !unit_fault_in &&
		(flash_disable_in || !(base_app_in || lost_superior_in));
	// Age counter, restarts on each state change
	always_comb begin
		age_next = age_reg;
		if (max_cooling_out != cool_reg) begin
			age_next = 0;
		end else if (age_reg < EVAL_CYCLES) begin
			age_next = age_reg + 1;
		end
	end
	// Registers, saturated at reset so a first change is free
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			age_reg <= EVAL_CYCLES;
			cool_reg <= 1'b0;
		end else begin
			age_reg <= age_next;
			cool_reg <= max_cooling_out;
		end
	end
	station_led_a: assert property (
		station_fault_led_out == $past(station_fault_in, 3))
		else $error("station lamp does not follow fault");
	unit_led_on_a: assert property (
		$past(unit_fault_in, 3) |-> unit_fault_led_out)
		else $error("unit lamp not steady on fault");
	unit_led_dark_a: assert property (
		$past(dark, 3) |-> !unit_fault_led_out)
		else $error("unit lamp lit without cause");
	fan_pulse_a: assert property (
		fan_cmd_out |=> !fan_cmd_out)
		else $error("fan command longer than one cycle");
	log_pulse_a: assert property (
		fault_log_out |=> !fault_log_out)
		else $error("fault log longer than one cycle");
	log_cause_a: assert property (
		fault_log_out |-> $past(fan_fail_in, 3))
		else $error("fault log without failure");
	cool_change_a: assert property (
		max_cooling_out != cool_reg |-> fan_cmd_out)
		else $error("state change without fan command");
	cool_hold_a: assert property (
		max_cooling_out != cool_reg |-> age_reg >= EVAL_CYCLES - 1)
		else $error("state changed too soon");
endmodule
bind cooling_and_fault_indicator_ctrl cooling_checker #(
	.EVAL_CYCLES(EVAL_CYCLES)
) i_cooling_checker (.clk_in, .rst_in, .unit_fault_in, .base_app_in,
	.lost_superior_in, .flash_disable_in, .station_fault_in,
	.fan_fail_in, .max_cooling_out, .fan_cmd_out, .fault_log_out,
	.unit_fault_led_out, .station_fault_led_out);

// File: fan_model.sv
`timescale 1ns/10ps
// Fan controller: takes commands, reports failure when asked
module fan_model (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic fan_cmd_in,     // Command strobe
	input  wire logic max_cooling_in, // Commanded level
	input  wire logic fail_mode_in,   // Report failure on each command
	output logic      fan_fail_out,   // Failure report, one cycle
	output logic      fan_max_out,    // Level in force
	output int        cmds_out        // Commands taken
);
	// Take each command; failure follows it by one cycle
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			fan_fail_out <= 1'b0;
			fan_max_out <= 1'b0;
			cmds_out <= 0;
		end else begin
			fan_fail_out <= fan_cmd_in && fail_mode_in;
			if (fan_cmd_in) begin
				fan_max_out <= max_cooling_in;
				cmds_out <= cmds_out + 1;
			end
		end
	end
endmodule

// File: cooling_and_fault_indicator_ctrl_test.sv
`timescale 1ns/10ps
module cooling_and_fault_indicator_ctrl_test;
	localparam int TW = cooling_pkg::TEMP_W;
	localparam logic [9:0] CRIT = cooling_pkg::CRIT_TEMP_RST;
	localparam logic [9:0] MARG = cooling_pkg::MARGIN_RST;
	logic        clk_in, rst_in, start_in, eres, fan_fail, fail_mode;
	logic [39:0] unit_temp_in;  // Four unit temperatures
	logic [3:0]  lim;           // Power limit flags
	logic        ufault, base, lost, fdis, sfault;
	logic        max_c, cmd, flog, uled, sled, fan_max;
	int          cmds, n_fail, checks, n_log, lit, cyc, tog;
	logic        prev;          // Last sampled unit lamp level
	cooling_and_fault_indicator_ctrl #(.EVAL_CYCLES(20), .FLASH_CYCLES(8))
	i_cooling_and_fault_indicator_ctrl (.clk_in, .rst_in, .unit_temp_in,
		.power_limited_in(lim), .critical_temperature_in(CRIT),
		.temp_margin_in(MARG), .start_in, .energy_unit_reset_in(eres),
		.fan_fail_in(fan_fail), .unit_fault_in(ufault), .base_app_in(base),
		.lost_superior_in(lost), .flash_disable_in(fdis),
		.station_fault_in(sfault), .max_cooling_out(max_c),
		.fan_cmd_out(cmd), .fault_log_out(flog), .unit_fault_led_out(uled),
		.station_fault_led_out(sled));
	fan_model i_fan_model (.clk_in, .rst_in, .fan_cmd_in(cmd),
		.max_cooling_in(max_c), .fail_mode_in(fail_mode),
		.fan_fail_out(fan_fail), .fan_max_out(fan_max), .cmds_out(cmds));
	////////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// Log pulse counter and hang guard
	always @(posedge clk_in) begin
		cyc++;
		if (flog === 1'b1) n_log++;
		if (cyc == 1000) begin
			n_fail++;
			$display("[FAIL] %0t cycle limit reached", $time);
			conclude();
		end
	end
	task step(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		{start_in, eres, fail_mode, lim, ufault, base, lost} = '0;
		{fdis, sfault, unit_temp_in} = '0;
		rst_in = 1'b1;
		step(10);
		rst_in <= 1'b0;
		unit_temp_in[3*TW+:TW] <= CRIT + 10'h001;
		step(8);
		chk(cmds, 0);
		start_in <= 1'b1;
		step(6);
		chk(max_c, 1);
		chk(fan_max, 1);
		unit_temp_in[3*TW+:TW] <= CRIT - MARG - 10'h001;
		step(8);
		chk(max_c, 1);
		step(20);
		chk(max_c, 0);
		lim <= 4'h2;
		step(28);
		chk(max_c, 1);
		lim <= 4'h0;
		unit_temp_in[0+:TW] <= CRIT - 10'h002;
		step(30);
		chk(max_c, 1);
		unit_temp_in[0+:TW] <= CRIT - MARG;
		step(30);
		chk(max_c, 1);
		unit_temp_in[0+:TW] <= CRIT - MARG - 10'h001;
		step(30);
		chk(max_c, 0);
		chk(cmds, 4);
		for (int f = 0; f < 2; f++) begin
			fail_mode <= (f == 1);
			eres <= 1'b1;
			step(3);
			eres <= 1'b0;
			step(10);
			chk(cmds, 5 + f);
			chk(n_log, f);
		end
		chk(max_c, 0);
		{ufault, base, sfault} <= 3'b111;
		step(5);
		chk(uled, 1);
		chk(sled, 1);
		{ufault, sfault} <= 2'b00;
		for (int m = 0; m < 3; m++) begin
			base <= (m == 0);
			lost <= (m != 0);
			fdis <= (m == 2);
			step(4);
			lit = 0;
			tog = 0;
			prev = uled;
			repeat (32) begin
				step(1);
				lit += uled;
				tog += (uled != prev);
				prev = uled;
			end
			chk(lit, (m == 2) ? 0 : 16);
			chk(tog, (m == 2) ? 0 : 4);
		end
		ufault <= 1'b1;
		step(5);
		rst_in <= 1'b1;
		step(1);
		chk(uled, 0);
		conclude();
	end
endmodule
